//--- verilog/cec_pkg.sv
package cec_pkg;

  // Clock and instruction-cycle timing.
  localparam int CEC_CLK_PERIOD_NS = 5;
  localparam int CEC_FCPU_PERIOD_NS = 250;
  localparam int CEC_FCPU_DIV = CEC_FCPU_PERIOD_NS / CEC_CLK_PERIOD_NS;
  localparam logic [7:0] CEC_FCPU_LAST = 8'(CEC_FCPU_DIV - 1);

  // Register indices and their byte addresses on the bus.
  localparam logic [11:0] CEC_IDX_CONTROL = 12'h09c;
  localparam logic [11:0] CEC_IDX_CONFIG = 12'h09d;
  localparam logic [11:0] CEC_IDX_STATUS = 12'h09e;
  localparam logic [11:0] CEC_IDX_MASK = 12'h09f;
  localparam logic [11:0] CEC_ADDR_CONTROL = 12'(CEC_IDX_CONTROL << 2);
  localparam logic [11:0] CEC_ADDR_CONFIG = 12'(CEC_IDX_CONFIG << 2);
  localparam logic [11:0] CEC_ADDR_STATUS = 12'(CEC_IDX_STATUS << 2);
  localparam logic [11:0] CEC_ADDR_MASK = 12'(CEC_IDX_MASK << 2);

  // Field positions of comparator_control.
  localparam int CEC_CTL_ON = 7;
  localparam int CEC_CTL_RESULT = 6;
  localparam int CEC_CTL_REF_HI = 5;
  localparam int CEC_CTL_REF_LO = 4;
  localparam int CEC_CTL_CH_HI = 3;
  localparam int CEC_CTL_CH_LO = 0;

  // Field positions of comparator_config.
  localparam int CEC_CFG_DEB_HI = 3;
  localparam int CEC_CFG_DEB_LO = 2;
  localparam int CEC_CFG_PIN_EN = 1;
  localparam int CEC_CFG_EDGE = 0;

  // Field positions of the status and mask registers.
  localparam int CEC_ST_EVENT = 0;
  localparam int CEC_ST_WAKE = 1;

  // Reset values.
  localparam logic [7:0] CEC_CONTROL_RST = 8'h40;
  localparam logic [7:0] CEC_CONFIG_RST = 8'h00;
  localparam logic [1:0] CEC_STATUS_RST = 2'h0;
  localparam logic [1:0] CEC_MASK_RST = 2'h0;

  // Debounce codes.
  localparam logic [1:0] CEC_DEB_NONE = 2'h3;

  // AXI responses.
  localparam logic [1:0] CEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CEC_RESP_SLVERR = 2'h2;

  // Analog and pin controls driven toward the comparator and port logic.
  typedef struct packed {
    logic ref_gen_enable;
    logic [1:0] ref_level_sel;
    logic [15:0] neg_input_takeover;
    logic result_pin;
    logic result_pin_oe;
  } cec_ana_t;

  // State of the three-stage input synchroniser.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } cec_sync_st_t;

  // State of the debounce filter.
  typedef struct packed {
    logic [1:0] cnt;
    logic q;
  } cec_deb_st_t;

endpackage : cec_pkg

//--- verilog/cec_sync.sv
`timescale 1ns/1ps
module cec_sync
  import cec_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous level in, settled level out.
  input wire logic din,
  output logic dout
);

  cec_sync_st_t st_r;
  cec_sync_st_t st_nxt;

  // The output follows only once the second and third stages agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule : cec_sync

//--- verilog/cec_debounce.sv
`timescale 1ns/1ps
module cec_debounce
  import cec_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Instruction-cycle tick and filter setting.
  input wire logic fcpu_tick,
  input wire logic [1:0] debounce_sel,
  // Result in and filtered result out.
  input wire logic din,
  output logic dout
);

  cec_deb_st_t st_r;
  cec_deb_st_t st_nxt;

  // A new level is accepted after it held for debounce_sel+1 instruction cycles, or at once for code 3.
  always_comb begin
    st_nxt = st_r;
    if (debounce_sel == CEC_DEB_NONE) begin
      st_nxt.q = din;
      st_nxt.cnt = 2'h0;
    end else if (din == st_r.q) begin
      st_nxt.cnt = 2'h0;
    end else if (fcpu_tick) begin
      if (st_r.cnt >= debounce_sel) begin
        st_nxt.q = din;
        st_nxt.cnt = 2'h0;
      end else begin
        st_nxt.cnt = st_r.cnt + 2'h1;
      end
    end
  end

  // State register; the idle comparator reads high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '{cnt: 2'h0, q: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule : cec_debounce

//--- verilog/cec_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Edge select 0 rising, 1 falling.
// - Selected edge sets the event flag.
// - Only software clears the event flag.
// - Interrupt only when flag and enable set.
// - Green mode wakes on either edge.
// - No wake request in power-down mode.
// - Matching wake edge also sets flag.
// - Debounce codes: one, two, three, none.
// - Edges come from the debounced result.
// - Reference level select, generator on while enabled.
// - Four-bit channel picks the negative pin.
// - Enabled: selected pin forced to input.
// - Deselected pin returns to general use.
// - Disabled: all sixteen pins stay general.
// - Result flag is raw, high when off.
// - Result high when reference exceeds input.
// - Pin enable drives result onto pin.
module cec_top
  import cec_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparator output and system power state.
  input wire logic cmp_raw,
  input wire logic green_mode,
  input wire logic power_down,
  // Analog controls, pin takeover and result pin.
  output cec_ana_t ana,
  // System requests.
  output logic wake_req,
  output logic irq
);

  // Whole module state.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic [7:0] control;
    logic [7:0] config_q;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] div_cnt;
    logic fcpu_tick;
    logic deb_prev;
    logic wake_req;
    logic irq;
    cec_ana_t ana;
  } cec_top_st_t;

  cec_top_st_t st_r;
  cec_top_st_t st_nxt;

  logic cmp_sync;
  logic cmp_eff;
  logic cmp_deb;
  logic cmp_on;

  // Reset image of the state.
  localparam cec_top_st_t CEC_TOP_RST = '{
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: CEC_RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rresp: CEC_RESP_OKAY,
    rdata: 32'h0000_0000,
    aw_got: 1'b0,
    aw_addr: 12'h000,
    w_got: 1'b0,
    w_data: 8'h00,
    w_lane0: 1'b0,
    control: CEC_CONTROL_RST,
    config_q: CEC_CONFIG_RST,
    status: CEC_STATUS_RST,
    mask: CEC_MASK_RST,
    div_cnt: 8'h00,
    fcpu_tick: 1'b0,
    deb_prev: 1'b1,
    wake_req: 1'b0,
    irq: 1'b0,
    ana: '0
  };

  // The comparator output is asynchronous to this clock.
  cec_sync #(
    .RST_VAL(1'b1)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(cmp_raw),
    .dout(cmp_sync)
  );

  // A disabled comparator reads as high.
  assign cmp_on = st_r.control[CEC_CTL_ON];
  assign cmp_eff = cmp_on ? cmp_sync : 1'b1;

  // Filter for the edge logic only; the result flag bypasses it.
  cec_debounce u_deb (
    .aclk(aclk),
    .aresetn(aresetn),
    .fcpu_tick(st_r.fcpu_tick),
    .debounce_sel(st_r.config_q[CEC_CFG_DEB_HI:CEC_CFG_DEB_LO]),
    .din(cmp_eff),
    .dout(cmp_deb)
  );

  // Register read mux; unmapped addresses answer with an error.
  function automatic logic [32:0] cec_read(input cec_top_st_t s, input logic [11:0] a,
                                           input logic res);
    logic [7:0] v;
    logic hit;
    v = 8'h00;
    hit = 1'b1;
    if (a == CEC_ADDR_CONTROL) begin
      v = s.control;
      v[CEC_CTL_RESULT] = res;
    end else if (a == CEC_ADDR_CONFIG) begin
      v = s.config_q;
    end else if (a == CEC_ADDR_STATUS) begin
      v = {6'h00, s.status};
    end else if (a == CEC_ADDR_MASK) begin
      v = {6'h00, s.mask};
    end else begin
      hit = 1'b0;
    end
    return {hit, 24'h000000, v};
  endfunction : cec_read

  // Next-state logic for bus, registers, edges and outputs.
  always_comb begin
    logic rise;
    logic fall;
    logic sel_edge;
    logic any_edge;
    logic do_write;
    logic [1:0] clr;
    logic [1:0] setb;
    logic [32:0] rd;
    rise = 1'b0;
    fall = 1'b0;
    sel_edge = 1'b0;
    any_edge = 1'b0;
    do_write = 1'b0;
    clr = 2'h0;
    setb = 2'h0;
    rd = 33'h0;
    st_nxt = st_r;

    // Instruction-cycle enable from the divider.
    st_nxt.fcpu_tick = 1'b0;
    if (st_r.div_cnt == CEC_FCPU_LAST) begin
      st_nxt.div_cnt = 8'h00;
      st_nxt.fcpu_tick = 1'b1;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 8'h01;
    end

    // Write address and data are taken independently.
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
      st_nxt.wready = 1'b0;
    end

    // Both halves held: perform the write if byte lane 0 is strobed, and answer.
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      do_write = st_r.w_lane0;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      rd = cec_read(st_r, st_r.aw_addr, 1'b0);
      st_nxt.bresp = rd[32] ? CEC_RESP_OKAY : CEC_RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end

    // Register stores; the result bit is read-only.
    if (do_write) begin
      if (st_r.aw_addr == CEC_ADDR_CONTROL) begin
        st_nxt.control = st_r.w_data;
        st_nxt.control[CEC_CTL_RESULT] = 1'b0;
      end else if (st_r.aw_addr == CEC_ADDR_CONFIG) begin
        st_nxt.config_q = {4'h0, st_r.w_data[3:0]};
      end else if (st_r.aw_addr == CEC_ADDR_STATUS) begin
        clr = st_r.w_data[1:0];
      end else if (st_r.aw_addr == CEC_ADDR_MASK) begin
        st_nxt.mask = st_r.w_data[1:0];
      end
    end

    // Read channel answers one cycle after the address is taken.
    if (s_axi_arvalid && st_r.arready) begin
      rd = cec_read(st_r, s_axi_araddr, cmp_eff);
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd[31:0];
      st_nxt.rresp = rd[32] ? CEC_RESP_OKAY : CEC_RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // Edge detection on the filtered result.
    st_nxt.deb_prev = cmp_deb;
    rise = cmp_deb && !st_r.deb_prev;
    fall = !cmp_deb && st_r.deb_prev;
    any_edge = rise || fall;
    sel_edge = st_r.config_q[CEC_CFG_EDGE] ? fall : rise;

    // Sticky events: a set in the clearing cycle wins.
    setb[CEC_ST_EVENT] = sel_edge;
    setb[CEC_ST_WAKE] = any_edge && green_mode && !power_down;
    st_nxt.status = (st_r.status & ~clr) | setb;

    // Green-mode wake request on either edge, never in power-down.
    st_nxt.wake_req = any_edge && green_mode && !power_down;

    // Interrupt level from unmasked sticky bits.
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);

    // Reference generator and level select.
    st_nxt.ana.ref_gen_enable = st_nxt.control[CEC_CTL_ON];
    st_nxt.ana.ref_level_sel = st_nxt.control[CEC_CTL_REF_HI:CEC_CTL_REF_LO];

    // Pin takeover follows the current channel while enabled.
    st_nxt.ana.neg_input_takeover = 16'h0000;
    if (st_nxt.control[CEC_CTL_ON]) begin
      st_nxt.ana.neg_input_takeover[st_nxt.control[CEC_CTL_CH_HI:CEC_CTL_CH_LO]] = 1'b1;
    end

    // Result pin drive; it follows the new enable so it reads high in the cycle it switches off.
    st_nxt.ana.result_pin = st_nxt.control[CEC_CTL_ON] ? cmp_sync : 1'b1;
    st_nxt.ana.result_pin_oe = st_nxt.config_q[CEC_CFG_PIN_EN];
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= CEC_TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign ana = st_r.ana;
  assign wake_req = st_r.wake_req;
  assign irq = st_r.irq;

endmodule : cec_top

//--- dv/cec_chk_sva.sv
`timescale 1ns/1ps
module cec_chk_sva
  import cec_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power state and block outputs.
  input wire logic green_mode,
  input wire logic power_down,
  input wire cec_ana_t ana,
  input wire logic wake_req,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A wake request needs green mode in the cycle before and power-down away.
  pd_wake_a: assert property (power_down && $past(power_down) |-> !wake_req)
    else $error("wake request in power-down");
  run_wake_a: assert property (!green_mode && !$past(green_mode) |-> !wake_req)
    else $error("wake request outside green mode");
  // Switched off, no pin is taken over and the result reads high.
  off_pins_a: assert property ($past(aresetn) && !ana.ref_gen_enable |->
    ana.neg_input_takeover == 16'h0 && ana.result_pin)
    else $error("pins taken while comparator off");
  one_pin_a: assert property (ana.ref_gen_enable |-> $onehot(ana.neg_input_takeover))
    else $error("takeover is not one pin");
  // Responses hold until taken, and no new write is accepted meanwhile.
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  // The interrupt only drops as a register write completes.
  irq_fall_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  wake_c: cover property (wake_req);
  irq_c: cover property ($rose(irq));
  read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule : cec_chk_sva

//--- dv/cec_ana_src.sv
`timescale 1ns/1ps
module cec_ana_src
  import cec_pkg::*;
#(
  parameter int VDD_MV = 3000
) (
  // Reference controls from the block.
  input wire cec_ana_t ana,
  // Voltage on the selected negative pin, in millivolts.
  input wire logic [11:0] neg_mv,
  // Comparator decision.
  output logic cmp_raw
);
  int ref_mv;
  // Reference level from the code; decision settles after an analog delay.
  always_comb ref_mv = VDD_MV * (ana.ref_level_sel == 2'h0 ? 1 : ana.ref_level_sel == 2'h1 ? 2 : 3) / 4;
  always @(ref_mv or neg_mv) cmp_raw <= #2 (ref_mv > int'(neg_mv));
endmodule : cec_ana_src

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import cec_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0, neg_mv = 12'd1000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, green_mode = 1'b0, power_down = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic wake_req, irq, cmp_raw;
  cec_ana_t ana;
  int n_fail = 0, total_checks = 0, n_wake = 0, w0;
  integer seed = 1586;
  logic [3:0] ch;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [1:0] dc[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  int dl[4] = '{40, 40, 40, 300};
  logic de[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  cec_top dut (.*);
  cec_ana_src u_src (.ana(ana), .neg_mv(neg_mv), .cmp_raw(cmp_raw));

  // Clock at 200 MHz.
  initial forever #2.5 aclk = ~aclk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Write one register; the expected response goes to the queue.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read one register; the expected data goes to the queue.
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Compares each response with the oldest note and counts wake pulses.
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (wake_req) n_wake++;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // Cuts a hung run short; the sequence needs about 2800 cycles.
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CEC_ADDR_CONTROL, CEC_CONTROL_RST, CEC_RESP_OKAY);
    rd(CEC_ADDR_CONFIG, CEC_CONFIG_RST, CEC_RESP_OKAY);
    wr(CEC_ADDR_CONTROL, 8'h0f, CEC_RESP_OKAY);
    rd(CEC_ADDR_CONTROL, 8'h4f, CEC_RESP_OKAY);
    wr(12'h000, 8'h01, CEC_RESP_SLVERR);
    rd(12'h004, 8'h00, CEC_RESP_SLVERR);
    chk(34'(ana.neg_input_takeover), 34'h0);
    // Every reference code and a random channel each time.
    for (int s = 0; s < 4; s++) begin
      ch = 4'($random(seed));
      neg_mv <= (s < 2) ? 12'd1200 : 12'd2000;
      wr(CEC_ADDR_CONTROL, {2'b10, 2'(s), ch}, CEC_RESP_OKAY);
      cyc(8);
      rd(CEC_ADDR_CONTROL, {1'b1, s != 0, 2'(s), ch}, CEC_RESP_OKAY);
      chk(34'(ana.neg_input_takeover), 34'(16'h1 << ch));
    end
    // Both edge directions, sticky flag, mask and result pin.
    wr(CEC_ADDR_CONTROL, 8'h90, CEC_RESP_OKAY);
    wr(CEC_ADDR_MASK, 8'h01, CEC_RESP_OKAY);
    for (int e = 0; e < 2; e++) begin
      wr(CEC_ADDR_CONFIG, {6'h03, 1'b1, e[0]}, CEC_RESP_OKAY);
      neg_mv <= 12'd2000;
      cyc(12);
      wr(CEC_ADDR_STATUS, 8'h03, CEC_RESP_OKAY);
      rd(CEC_ADDR_STATUS, 8'h00, CEC_RESP_OKAY);
      chk({ana.result_pin, ana.result_pin_oe, irq}, 34'h2);
      neg_mv <= 12'd1000;
      cyc(12);
      rd(CEC_ADDR_STATUS, {7'h0, !e[0]}, CEC_RESP_OKAY);
      chk(34'(irq), 34'(!e[0]));
      neg_mv <= 12'd2000;
      cyc(12);
      rd(CEC_ADDR_STATUS, 8'h01, CEC_RESP_OKAY);
      wr(CEC_ADDR_MASK, 8'h00, CEC_RESP_OKAY);
      chk(34'(irq), 34'h0);
      wr(CEC_ADDR_MASK, 8'h01, CEC_RESP_OKAY);
      chk(34'(irq), 34'h1);
    end
    // Pulses shorter than the filter time are dropped.
    neg_mv <= 12'd1000;
    cyc(400);
    for (int i = 0; i < 4; i++) begin
      wr(CEC_ADDR_CONFIG, {4'h0, dc[i], 2'b00}, CEC_RESP_OKAY);
      wr(CEC_ADDR_STATUS, 8'h03, CEC_RESP_OKAY);
      neg_mv <= 12'd2000;
      cyc(dl[i]);
      neg_mv <= 12'd1000;
      cyc(400);
      rd(CEC_ADDR_STATUS, {7'h0, de[i]}, CEC_RESP_OKAY);
    end
    // Green mode wakes on both edges, power-down on none.
    wr(CEC_ADDR_CONFIG, 8'h0d, CEC_RESP_OKAY);
    wr(CEC_ADDR_STATUS, 8'h03, CEC_RESP_OKAY);
    w0 = n_wake;
    green_mode <= 1'b1;
    neg_mv <= 12'd2000;
    cyc(12);
    rd(CEC_ADDR_STATUS, 8'h03, CEC_RESP_OKAY);
    wr(CEC_ADDR_STATUS, 8'h03, CEC_RESP_OKAY);
    neg_mv <= 12'd1000;
    cyc(12);
    rd(CEC_ADDR_STATUS, 8'h02, CEC_RESP_OKAY);
    chk(34'(n_wake - w0), 34'h2);
    power_down <= 1'b1;
    neg_mv <= 12'd2000;
    cyc(12);
    chk(34'(n_wake - w0), 34'h2);
    wr(CEC_ADDR_CONTROL, 8'h00, CEC_RESP_OKAY);
    cyc(4);
    chk({ana.neg_input_takeover, ana.result_pin}, 34'h1);
    // A second reset restores the register defaults.
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rd(CEC_ADDR_MASK, 8'h00, CEC_RESP_OKAY);
    rd(CEC_ADDR_CONTROL, CEC_CONTROL_RST, CEC_RESP_OKAY);
    report_and_stop();
  end
endmodule : tb_top

bind cec_top cec_chk_sva u_chk (.*);
